// ---- bench/srs_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module srs_assertions (
  input wire logic                           CORE_CLK,
  input wire logic                           RSTN,
  input wire logic                           scl,
  input wire logic                           sda,
  input wire logic                           dev_sda_oe_n,
  input wire logic                           STANDBY,
  input wire logic [srs_pkg::MEM_ADDR_W-1:0] ADDR_PTR
);
  import srs_pkg::*;
  logic       scl_reg, sda_reg, rd_reg, nak_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg, byte_reg;
  wire logic  rise  = scl && !scl_reg;
  wire logic  start = scl && scl_reg && sda_reg && !sda;
  wire logic  stop  = scl && scl_reg && !sda_reg && sda;
  wire logic  ninth = rise && (cnt_reg == 4'h8);

  // bit and byte position within a frame; start or stop restarts the count
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_reg  <= 1'b1;
      sda_reg  <= 1'b1;
      cnt_reg  <= 4'h0;
      byte_reg <= 8'h00;
      sh_reg   <= 8'h00;
      rd_reg   <= 1'b0;
      nak_reg  <= 1'b0;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      if (start || stop) begin
        cnt_reg  <= 4'h0;
        byte_reg <= 8'h00;
        rd_reg   <= 1'b0;
        nak_reg  <= 1'b0;
      end else if (rise) begin
        sh_reg  <= {sh_reg[6:0], sda};
        cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
        if (cnt_reg == 4'h9) byte_reg <= byte_reg + 8'h01;
        if (byte_reg == 8'h00 && cnt_reg == 4'h7) rd_reg <= sda;
        if (ninth && rd_reg && byte_reg != 8'h00 && sda) nak_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  AST_ADDR_ACK: assert property (
    ninth && byte_reg == 8'h00 && sh_reg[7:4] == DEV_TYPE_CODE |-> !sda)
    else $error("address byte not acknowledged");
  AST_WORD_ACK: assert property (
    ninth && byte_reg == 8'h01 && !rd_reg |-> !sda)
    else $error("word address not acknowledged");
  AST_HOST_ACK_FREE: assert property (
    ninth && rd_reg && byte_reg != 8'h00 |-> dev_sda_oe_n [*4])
    else $error("device drove data during host acknowledge");
  AST_NEXT_BYTE: assert property (
    ninth && rd_reg && byte_reg != 8'h00 && !sda |-> ##[1:400] !dev_sda_oe_n)
    else $error("no further byte after host acknowledge");
  AST_NACK_QUIET: assert property (
    nak_reg |-> dev_sda_oe_n)
    else $error("device drives after host no-acknowledge");
  AST_PTR_STEP: assert property (
    rd_reg && $changed(ADDR_PTR) |-> ADDR_PTR == MEM_ADDR_W'($past(ADDR_PTR) + 1'b1))
    else $error("address counter did not step by one");
  AST_STOP_STANDBY: assert property (
    stop |-> ##[0:10] STANDBY)
    else $error("no standby after stop");
  AST_CHANGE_LOW: assert property (
    $changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed data while clock high");
  AST_START_LISTEN: assert property (
    start |-> dev_sda_oe_n [*8])
    else $error("device drives after start");
endmodule
`default_nettype wire

// ---- bench/srs_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module srs_bench;
  import srs_pkg::*;
  logic                  core_clk, rstn, mem_we, cmd_valid, cmd_random, out_ready;
  logic                  standby, cmd_ready, out_valid, nack_err;
  logic [MEM_ADDR_W-1:0] mem_waddr, cmd_waddr, addr_ptr, exp_ptr;
  logic [DATA_W-1:0]     mem_wdata, out_data;
  logic [7:0]            cmd_len;
  int                    errors, comparisons, cyc, low_run;

  srs_link_if link ();
  srs_device_end u_srs_device_end (.CORE_CLK(core_clk), .RSTN(rstn), .LINK(link),
    .MEM_WE(mem_we), .MEM_WADDR(mem_waddr), .MEM_WDATA(mem_wdata), .STANDBY(standby),
    .ADDR_PTR(addr_ptr));
  srs_host_end u_srs_host_end (.CORE_CLK(core_clk), .RSTN(rstn), .LINK(link),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_RANDOM(cmd_random),
    .CMD_WADDR(cmd_waddr), .CMD_LEN(cmd_len), .OUT_VALID(out_valid), .OUT_READY(out_ready),
    .OUT_DATA(out_data), .NACK_ERR(nack_err));
  srs_assertions u_srs_assertions (.CORE_CLK(core_clk), .RSTN(rstn), .scl(link.scl),
    .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n), .STANDBY(standby), .ADDR_PTR(addr_ptr));

  // array contents: msb kept zero so every byte pulls the line low at least once
  function automatic logic [DATA_W-1:0] pat(input logic [MEM_ADDR_W-1:0] a);
    return {1'b0, a[6:0]};
  endfunction

  task automatic close_out();
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one command, released at the negedge after the edge that takes it
  task automatic issue(input logic rnd, input logic [7:0] wa, input logic [7:0] ln);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    cmd_valid  = 1'b1;
    cmd_random = rnd;
    cmd_waddr  = wa;
    cmd_len    = ln;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask

  // pop n bytes in link order, then look at what the stop left behind
  task automatic drain(input int n);
    int i;
    i = 0;
    while (i < n) begin
      if (out_valid === 1'b1) begin
        `CHK("out_data", pat(exp_ptr), out_data)
        exp_ptr++;
        i++;
      end
      out_ready = 1'b1;
      @(negedge core_clk);
    end
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    // standby comes a few cycles late through the device's synchroniser
    for (int k = 0; k < 16 && standby !== 1'b1; k++) @(negedge core_clk);
    `CHK("standby", 1'b1, standby)
    `CHK("addr_ptr", exp_ptr, addr_ptr)
    `CHK("nack_err", 1'b0, nack_err)
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // watchdog: the planned traffic needs roughly 70k cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    {rstn, mem_we, cmd_valid, cmd_random, out_ready} = 5'h00;
    {mem_waddr, mem_wdata, cmd_waddr, cmd_len} = 32'h0000_0000;
    exp_ptr = 8'h00;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    // idle levels while still in reset
    `CHK("scl", 1'b1, link.scl)
    `CHK("host_oe_n", 1'b1, link.host_sda_oe_n)
    `CHK("dev_oe_n", 1'b1, link.dev_sda_oe_n)
    `CHK("standby", 1'b1, standby)
    `CHK("addr_ptr", 8'h00, addr_ptr)
    `CHK("cmd_ready", 1'b1, cmd_ready)
    `CHK("out_valid", 1'b0, out_valid)
    rstn = 1'b1;
    // backdoor fill of the whole array
    for (int a = 0; a < 256; a++) begin
      mem_we    = 1'b1;
      mem_waddr = 8'(a);
      mem_wdata = pat(8'(a));
      @(negedge core_clk);
    end
    mem_we = 1'b0;
    // dummy write, repeated start, one byte
    exp_ptr = 8'h3C;
    issue(1'b1, 8'h3C, 8'h01);
    drain(1);
    // current-address reads carry on from the counter; length zero reads one byte
    issue(1'b0, 8'h00, 8'h02);
    drain(2);
    issue(1'b0, 8'h00, 8'h00);
    drain(1);
    // long read over the top of the array with the stream stalled until the fifo fills
    out_ready = 1'b0;
    exp_ptr   = 8'hF8;
    issue(1'b1, 8'hF8, 8'h11);
    low_run = 0;
    while (low_run < 600) begin
      @(negedge core_clk);
      low_run = (link.scl === 1'b0) ? low_run + 1 : 0;
    end
    `CHK("cmd_ready", 1'b0, cmd_ready)
    `CHK("out_valid", 1'b1, out_valid)
    drain(17);
    close_out();
  end
endmodule
`undef CHK
`default_nettype wire

// ---- core/srs_device_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module srs_device_end #(
  parameter int ADDR_W = srs_pkg::MEM_ADDR_W
) (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RSTN,
  srs_link_if.dev                        LINK,
  input  wire logic                      MEM_WE,
  input  wire logic [ADDR_W-1:0]         MEM_WADDR,
  input  wire logic [srs_pkg::DATA_W-1:0] MEM_WDATA,
  output logic                           STANDBY,
  output logic [ADDR_W-1:0]              ADDR_PTR
);
  import srs_pkg::*;

  typedef struct packed {
    logic [2:0]     scl_s;
    logic [2:0]     sda_s;
    srs_dev_state_t st;
    logic [3:0]     cnt;
    logic [7:0]     sh;
    logic           rw;
    logic           more;
    logic [ADDR_W-1:0] ptr;
    logic           sda_oe_n;
    logic           standby;
  } srs_dev_reg_t;

  srs_dev_reg_t r_reg;
  srs_dev_reg_t r_next;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] rd_byte;
  logic              scl_hi;
  logic              sda_in;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_seen;
  logic              stop_seen;

  // backdoor fill; the array has no reset, contents are whatever was loaded
  always_ff @(posedge CORE_CLK) begin
    if (MEM_WE) begin
      mem[MEM_WADDR] <= MEM_WDATA;
    end
  end

  assign rd_byte = mem[r_reg.ptr];

  // edges are taken only from the second sync stage and its delayed copy
  assign scl_hi     = r_reg.scl_s[1];
  assign sda_in     = r_reg.sda_s[1];
  assign scl_rise   = r_reg.scl_s[1] & ~r_reg.scl_s[2];
  assign scl_fall   = ~r_reg.scl_s[1] & r_reg.scl_s[2];
  assign start_seen = scl_hi & r_reg.scl_s[2] & ~r_reg.sda_s[1] & r_reg.sda_s[2];
  assign stop_seen  = scl_hi & r_reg.scl_s[2] & r_reg.sda_s[1] & ~r_reg.sda_s[2];

  // next-state logic for the whole protocol engine
  always_comb begin
    r_next       = r_reg;
    r_next.scl_s = {r_reg.scl_s[1:0], LINK.scl};
    r_next.sda_s = {r_reg.sda_s[1:0], LINK.sda};
    if (start_seen) begin
      // a start wins over anything in flight, even mid-byte
      r_next.st       = DS_RX_DEV;
      r_next.cnt      = '0;
      r_next.sda_oe_n = 1'b1;
      r_next.standby  = 1'b0;
    end else if (stop_seen) begin
      r_next.st       = DS_IDLE;
      r_next.sda_oe_n = 1'b1;
      r_next.standby  = 1'b1;
    end else if (scl_rise) begin
      case (r_reg.st)
        DS_RX_DEV, DS_RX_WORD: begin
          r_next.sh  = {r_reg.sh[6:0], sda_in};
          r_next.cnt = r_reg.cnt + 4'h1;
        end
        DS_HOST_ACK: begin
          r_next.more = (sda_in == ACK_BIT);
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (r_reg.st)
        DS_RX_DEV: begin
          if (r_reg.cnt == BYTE_BITS) begin
            // only the type nibble is checked, select bits are don't-care
            if (r_reg.sh[7:4] == DEV_TYPE_CODE) begin
              r_next.rw       = r_reg.sh[0];
              r_next.sda_oe_n = SDA_LOW;
              r_next.st       = DS_ACK_DEV;
            end else begin
              r_next.st = DS_WAIT;
            end
          end
        end
        DS_ACK_DEV: begin
          if (r_reg.rw == RW_READ) begin
            // first data bit goes out on the fall that ends the ack clock
            r_next.sda_oe_n = rd_byte[7];
            r_next.sh       = {rd_byte[6:0], 1'b0};
            r_next.cnt      = 4'h1;
            r_next.ptr      = r_reg.ptr + 1'b1;
            r_next.st       = DS_TX;
          end else begin
            r_next.sda_oe_n = 1'b1;
            r_next.cnt      = '0;
            r_next.st       = DS_RX_WORD;
          end
        end
        DS_RX_WORD: begin
          if (r_reg.cnt == BYTE_BITS) begin
            r_next.ptr      = r_reg.sh[ADDR_W-1:0];
            r_next.sda_oe_n = SDA_LOW;
            r_next.st       = DS_ACK_WORD;
          end
        end
        DS_ACK_WORD: begin
          // write data is not stored; the controller restarts for the read
          r_next.sda_oe_n = 1'b1;
          r_next.st       = DS_WAIT;
        end
        DS_TX: begin
          if (r_reg.cnt == BYTE_BITS) begin
            r_next.sda_oe_n = 1'b1;
            r_next.st       = DS_HOST_ACK;
          end else begin
            r_next.sda_oe_n = r_reg.sh[7];
            r_next.sh       = {r_reg.sh[6:0], 1'b0};
            r_next.cnt      = r_reg.cnt + 4'h1;
          end
        end
        DS_HOST_ACK: begin
          if (r_reg.more) begin
            r_next.sda_oe_n = rd_byte[7];
            r_next.sh       = {rd_byte[6:0], 1'b0};
            r_next.cnt      = 4'h1;
            r_next.ptr      = r_reg.ptr + 1'b1;
            r_next.st       = DS_TX;
          end else begin
            // no-acknowledge: stay off the line until start or stop
            r_next.st = DS_WAIT;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // line idles high, so the sync chains reset to one to avoid a false edge
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_reg          <= '0;
      r_reg.scl_s    <= 3'h7;
      r_reg.sda_s    <= 3'h7;
      r_reg.st       <= DS_IDLE;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.standby  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign LINK.dev_sda_o    = SDA_LOW;
  assign LINK.dev_sda_oe_n = r_reg.sda_oe_n;
  assign STANDBY           = r_reg.standby;
  assign ADDR_PTR          = r_reg.ptr;
endmodule
`default_nettype wire

// ---- core/srs_host_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module srs_fifo #(
  parameter int WIDTH = srs_pkg::DATA_W,
  parameter int DEPTH = srs_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          full;
    logic          empty;
  } srs_fifo_reg_t;

  srs_fifo_reg_t  f_reg;
  srs_fifo_reg_t  f_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic           push;
  logic           pop;

  assign push = in_valid & ~f_reg.full;
  assign pop  = out_ready & ~f_reg.empty;

  // pointers wrap naturally, so depth must be a power of two
  always_comb begin
    f_next = f_reg;
    if (push) begin
      f_next.wr = f_reg.wr + 1'b1;
    end
    if (pop) begin
      f_next.rd = f_reg.rd + 1'b1;
    end
    f_next.cnt   = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    f_next.full  = (f_next.cnt == (AW+1)'(DEPTH));
    f_next.empty = (f_next.cnt == '0);
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[f_reg.wr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      f_reg       <= '0;
      f_reg.empty <= 1'b1;
    end else begin
      f_reg <= f_next;
    end
  end

  assign in_ready  = ~f_reg.full;
  assign out_valid = ~f_reg.empty;
  assign out_data  = mem[f_reg.rd];
endmodule

module srs_host_end (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RSTN,
  srs_link_if.host                       LINK,
  input  wire logic                      CMD_VALID,
  output logic                           CMD_READY,
  input  wire logic                      CMD_RANDOM,
  input  wire logic [srs_pkg::MEM_ADDR_W-1:0] CMD_WADDR,
  input  wire logic [7:0]                CMD_LEN,
  output logic                           OUT_VALID,
  input  wire logic                      OUT_READY,
  output logic [srs_pkg::DATA_W-1:0]     OUT_DATA,
  output logic                           NACK_ERR
);
  import srs_pkg::*;

  typedef struct packed {
    srs_host_state_t st;
    srs_stage_t      stage;
    logic [QTR_W-1:0] qcnt;
    logic [1:0]      ph;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [7:0]      left;
    logic [7:0]      waddr;
    logic            got_nack;
    logic [1:0]      sda_s;
    logic            scl;
    logic            sda_oe_n;
    logic            ready;
    logic            err;
    logic            push;
  } srs_host_reg_t;

  srs_host_reg_t r_reg;
  srs_host_reg_t r_next;
  logic          fifo_ready;
  logic          tick;

  // scl is made here by dividing the core clock into quarter-bit ticks
  assign tick = (r_reg.qcnt == QTR_LAST);

  always_comb begin
    r_next       = r_reg;
    r_next.sda_s = {r_reg.sda_s[0], LINK.sda};
    r_next.push  = 1'b0;
    r_next.qcnt  = tick ? '0 : r_reg.qcnt + 1'b1;
    if (tick) begin
      r_next.ph = r_reg.ph + 2'h1;
    end
    case (r_reg.st)
      HS_IDLE: begin
        r_next.qcnt = '0;
        r_next.ph   = PH_SET;
        if (CMD_VALID && r_reg.ready) begin
          r_next.ready = 1'b0;
          r_next.err   = 1'b0;
          r_next.waddr = CMD_WADDR;
          r_next.left  = (CMD_LEN == 8'h00) ? 8'h01 : CMD_LEN;
          r_next.stage = CMD_RANDOM ? STG_DEVW : STG_DEVR;
          r_next.st    = HS_START;
        end
      end
      HS_START: begin
        if (tick) begin
          case (r_reg.ph)
            PH_SET:    r_next.sda_oe_n = 1'b1;
            PH_RISE:   r_next.scl = 1'b1;
            PH_SAMPLE: r_next.sda_oe_n = SDA_LOW;
            default: begin
              r_next.scl = 1'b0;
              r_next.cnt = '0;
              // address byte: type nibble, don't-care selects, direction
              r_next.sh  = {DEV_TYPE_CODE, DEV_SEL_BITS,
                            (r_reg.stage == STG_DEVW) ? RW_WRITE : RW_READ};
              r_next.st  = HS_TX;
            end
          endcase
        end
      end
      HS_TX: begin
        if (tick) begin
          case (r_reg.ph)
            PH_SET:    r_next.sda_oe_n = (r_reg.cnt == BYTE_BITS) ? 1'b1 : r_reg.sh[7];
            PH_RISE:   r_next.scl = 1'b1;
            PH_SAMPLE: r_next.got_nack = r_reg.sda_s[1];
            default: begin
              r_next.scl = 1'b0;
              r_next.sh  = {r_reg.sh[6:0], 1'b0};
              r_next.cnt = r_reg.cnt + 4'h1;
              if (r_reg.cnt == BYTE_BITS) begin
                r_next.cnt = '0;
                if (r_reg.got_nack) begin
                  r_next.err = 1'b1;
                  r_next.st  = HS_STOP;
                end else if (r_reg.stage == STG_DEVW) begin
                  r_next.stage = STG_WADDR;
                  r_next.sh    = r_reg.waddr;
                end else if (r_reg.stage == STG_WADDR) begin
                  // no write data: restart straight into a read
                  r_next.stage = STG_DEVR;
                  r_next.st    = HS_START;
                end else begin
                  r_next.st = HS_ROOM;
                end
              end
            end
          endcase
        end
      end
      HS_ROOM: begin
        // the clock is held low until the fifo can take a whole byte
        r_next.qcnt = '0;
        r_next.ph   = PH_SET;
        if (fifo_ready) begin
          r_next.st = HS_RX;
        end
      end
      HS_RX: begin
        if (tick) begin
          case (r_reg.ph)
            PH_SET: begin
              if (r_reg.cnt == BYTE_BITS) begin
                r_next.sda_oe_n = (r_reg.left == 8'h01) ? NACK_BIT : ACK_BIT;
              end else begin
                r_next.sda_oe_n = 1'b1;
              end
            end
            PH_RISE:   r_next.scl = 1'b1;
            PH_SAMPLE: begin
              if (r_reg.cnt != BYTE_BITS) begin
                r_next.sh = {r_reg.sh[6:0], r_reg.sda_s[1]};
              end
            end
            default: begin
              r_next.scl  = 1'b0;
              r_next.cnt  = r_reg.cnt + 4'h1;
              r_next.push = (r_reg.cnt == (BYTE_BITS - 4'h1));
              if (r_reg.cnt == BYTE_BITS) begin
                r_next.cnt  = '0;
                r_next.left = r_reg.left - 8'h01;
                r_next.st   = (r_reg.left == 8'h01) ? HS_STOP : HS_ROOM;
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          case (r_reg.ph)
            PH_SET:    r_next.sda_oe_n = SDA_LOW;
            PH_RISE:   r_next.scl = 1'b1;
            PH_SAMPLE: r_next.sda_oe_n = 1'b1;
            default: begin
              r_next.ready = 1'b1;
              r_next.st    = HS_IDLE;
            end
          endcase
        end
      end
      default: r_next.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_reg          <= '0;
      r_reg.st       <= HS_IDLE;
      r_reg.sda_s    <= 2'h3;
      r_reg.scl      <= 1'b1;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.ready    <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // received bytes queue up here; a full queue stalls the link clock
  srs_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rstn      (RSTN),
    .in_valid  (r_reg.push),
    .in_ready  (fifo_ready),
    .in_data   (r_reg.sh),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_DATA)
  );

  assign LINK.scl           = r_reg.scl;
  assign LINK.host_sda_o    = SDA_LOW;
  assign LINK.host_sda_oe_n = r_reg.sda_oe_n;
  assign CMD_READY          = r_reg.ready;
  assign NACK_ERR           = r_reg.err;
endmodule
`default_nettype wire

// ---- core/srs_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface srs_link_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // open-drain wired-and with a pull-up
  assign sda = ((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o)) ? 1'b0 : 1'b1;

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );
  modport host (
    output scl,
    input  sda,
    output host_sda_o,
    output host_sda_oe_n
  );
endinterface
`default_nettype wire

// ---- core/srs_pkg.sv ----
// Notes on behaviour
// - read address byte is acknowledged on ninth clock
// - send one byte at counter, then advance counter
// - controller acknowledges eighteenth clock for another byte
// - every acknowledged byte is followed by another
// - counter wraps to zero past the top
// - controller ends read with no-acknowledge, then stop
// - random read opens with a write-mode address
// - word address is acknowledged and loads the counter
// - controller restarts with a current-address read
// - any start abandons work and takes new command
// - address byte: 1010, three ignored, then read/write
// - counter keeps last accessed address plus one
// - device pulls data low on ninth clock
// - stop after a read returns to standby
package srs_pkg;
  localparam int unsigned CORE_PERIOD_NS = 10;
  localparam int unsigned SCL_PERIOD_NS  = 2500;
  // quarter of a bit time on the link, in core cycles
  localparam int unsigned SCL_QTR_CYC    = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);
  localparam int          QTR_W          = 8;
  localparam logic [QTR_W-1:0] QTR_LAST  = QTR_W'(SCL_QTR_CYC - 1);
  localparam int          MEM_ADDR_W     = 8;
  localparam int          DATA_W         = 8;
  localparam int          FIFO_DEPTH     = 16;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam logic [3:0]  DEV_TYPE_CODE  = 4'hA;
  localparam logic [2:0]  DEV_SEL_BITS   = 3'h0;
  localparam logic        RW_READ        = 1'b1;
  localparam logic        RW_WRITE       = 1'b0;
  localparam logic        ACK_BIT        = 1'b0;
  localparam logic        NACK_BIT       = 1'b1;
  localparam logic        SDA_LOW        = 1'b0;
  localparam logic [1:0]  PH_SET         = 2'h0;
  localparam logic [1:0]  PH_RISE        = 2'h1;
  localparam logic [1:0]  PH_SAMPLE      = 2'h2;
  localparam logic [1:0]  PH_FALL        = 2'h3;

  typedef enum logic [2:0] {
    DS_IDLE, DS_RX_DEV, DS_ACK_DEV, DS_RX_WORD, DS_ACK_WORD, DS_TX, DS_HOST_ACK, DS_WAIT
  } srs_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_TX, HS_ROOM, HS_RX, HS_STOP
  } srs_host_state_t;

  typedef enum logic [1:0] {
    STG_DEVW, STG_WADDR, STG_DEVR
  } srs_stage_t;
endpackage
